// ### logic/iocra_pkg.sv
// Shared constants for the I/O channel request arbiter.
// Assumes one 50 MHz system clock shared by processor and channel logic.
package iocra_pkg;

  // ****************************************************************
  // Channel numbering
  // ****************************************************************
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam logic [2:0] CH_MUX = 3'h0;
  localparam logic [2:0] CH_SEL1 = 3'h1;
  localparam logic [2:0] CH_SEL2 = 3'h2;
  localparam logic [2:0] CH_SEL3 = 3'h3;
  localparam logic [2:0] CH_SEL4 = 3'h4;
  localparam logic [2:0] CH_COMMS = 3'h5;
  localparam logic [2:0] CH_STORE_FAC = 3'h6;
  localparam logic [2:0] CH_UNUSED = 3'h7;

  // ****************************************************************
  // Priority orders, rank 0 (highest) in the low three bits
  // ****************************************************************
  localparam logic [23:0] STOR_ORDER = {CH_MUX, CH_UNUSED, CH_SEL4, CH_SEL3,
                                        CH_COMMS, CH_SEL2, CH_SEL1, CH_STORE_FAC};
  localparam logic [23:0] LEVEL_ORDER = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int OP_W = 4;
  localparam int DEV_W = 8;
  localparam int CC_W = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STOR_CYCLE_NS = 20;
  localparam int STOR_CYCLES = (STOR_CYCLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                               (STOR_CYCLE_NS / CLK_PERIOD_NS);
  localparam logic [3:0] STOR_CNT_RST = 4'h0;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

  typedef enum logic [1:0] {
    IOCRA_ST_IDLE,
    IOCRA_ST_GRANT,
    IOCRA_ST_RECOVER
  } iocra_stor_state_t;

endpackage : iocra_pkg

// ### logic/iocra_picker.sv
// Fixed-order picker: selects the highest ranked active request.
// Assumes requests are stable for the cycle in which they are sampled.
`timescale 1ns/1ns
module iocra_picker #(
  parameter logic [23:0] ORDER = iocra_pkg::LEVEL_ORDER
) (
  input wire logic [7:0] req_i,
  output logic valid_o,
  output logic [2:0] idx_o
);

  // ****************************************************************
  // Scan from lowest rank upward so the highest rank wins
  // ****************************************************************
  always_comb
  begin
    valid_o = 1'b0;
    idx_o = 3'h0;
    for (int r = 7; r >= 0; r--)
    begin
      if (req_i[ORDER[r*3 +: 3]])
      begin
        valid_o = 1'b1;
        idx_o = ORDER[r*3 +: 3];
      end
    end
  end

endmodule : iocra_picker

// ### logic/iocra_top.sv
// Processor-side arbiter for eight I/O channels: storage grants,
// interrupt priority and I/O instruction handshake.
// Assumes channel logic runs on core_clk_i; no input crosses a domain.
// Functional notes
// - Ports for eight channels: storage, interrupt and instruction signals each.
// - Channels are numbered 0 to 7 by a 3-bit code.
// - Storage and interrupt order are independent of channel number.
// - 0 multiplexer, 1-4 selectors, 5 comms processor, 6 storage facility, 7 spare.
// - Instruction start sends opcode bits, device address and request to channel.
// - One requester wins by storage priority and only it gets grant.
// - Grant lasts exactly one storage cycle, then channel must rearbitrate.
// - Storage error indications are routed to the granted channel.
// - One requester wins by interrupt priority and gets its priority signal.
// - Storage priority: 6, 1, 2, 5, 3, 4, 7, then 0.
// - Eight interrupt levels: 6, 1, 2, 3, 4, 5, mux standard, mux table.
`timescale 1ns/1ns
module iocra_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Storage interface
  input wire logic [7:0] stor_req_i,
  input wire logic stor_adr_exc_i,
  input wire logic stor_prot_exc_i,
  input wire logic stor_adr_chk_i,
  input wire logic stor_par_chk_i,
  output logic [7:0] stor_gnt_o,
  output logic [7:0] stor_adr_exc_o,
  output logic [7:0] stor_prot_exc_o,
  output logic [7:0] stor_adr_chk_o,
  output logic [7:0] stor_par_chk_o,
  // Interrupt interface
  input wire logic [7:0] int_req_i,
  input wire logic mux_table_req_i,
  output logic [7:0] int_prio_o,
  output logic mux_table_prio_o,
  output logic [2:0] int_chan_o,
  // Instruction interface, processor side
  input wire logic instr_start_i,
  input wire logic [2:0] instr_chan_i,
  input wire logic [iocra_pkg::OP_W-1:0] instr_op_i,
  input wire logic [iocra_pkg::DEV_W-1:0] instr_dev_i,
  output logic instr_busy_o,
  output logic instr_done_o,
  output logic [iocra_pkg::CC_W-1:0] instr_cc_o,
  // Instruction interface, channel side
  output logic [7:0] instr_req_o,
  output logic [iocra_pkg::OP_W-1:0] instr_op_o,
  output logic [iocra_pkg::DEV_W-1:0] instr_dev_o,
  input wire logic [7:0] instr_ack_i,
  input wire logic [15:0] instr_cc_i
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_q <= iocra_pkg::RST_SYNC_RST;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Storage arbitration
  // ****************************************************************
  iocra_pkg::iocra_stor_state_t st_q, st_d;
  logic [3:0] stor_cnt_q, stor_cnt_d;
  logic stor_any;
  logic [2:0] stor_idx;
  logic [7:0] stor_sel;
  logic [7:0] stor_gnt_d;
  logic stor_last;

  iocra_picker #(
    .ORDER(iocra_pkg::STOR_ORDER)
  ) u_stor_pick (
    .req_i(stor_req_i),
    .valid_o(stor_any),
    .idx_o(stor_idx)
  );

  assign stor_sel = 8'h01 << stor_idx;
  assign stor_last = (stor_cnt_q == 4'(iocra_pkg::STOR_CYCLES - 1));

  always_comb
  begin
    st_d = st_q;
    stor_cnt_d = stor_cnt_q;
    stor_gnt_d = stor_gnt_o;
    unique case (st_q)
      iocra_pkg::IOCRA_ST_IDLE:
      begin
        if (stor_any)
        begin
          st_d = iocra_pkg::IOCRA_ST_GRANT;
          stor_gnt_d = stor_sel;
          stor_cnt_d = iocra_pkg::STOR_CNT_RST;
        end
      end
      iocra_pkg::IOCRA_ST_GRANT:
      begin
        stor_cnt_d = stor_cnt_q + 4'h1;
        if (stor_last)
        begin
          // One storage cycle only; the gap lets the request fall first
          st_d = iocra_pkg::IOCRA_ST_RECOVER;
          stor_gnt_d = 8'h00;
        end
      end
      iocra_pkg::IOCRA_ST_RECOVER:
        st_d = iocra_pkg::IOCRA_ST_IDLE;
      default:
      begin
        st_d = iocra_pkg::IOCRA_ST_IDLE;
        stor_gnt_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= iocra_pkg::IOCRA_ST_IDLE;
      stor_cnt_q <= iocra_pkg::STOR_CNT_RST;
      stor_gnt_o <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      stor_cnt_q <= stor_cnt_d;
      stor_gnt_o <= stor_gnt_d;
    end
  end

  // Errors go, one cycle later, only to the channel that held the grant
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stor_adr_exc_o <= 8'h00;
      stor_prot_exc_o <= 8'h00;
      stor_adr_chk_o <= 8'h00;
      stor_par_chk_o <= 8'h00;
    end
    else
    begin
      stor_adr_exc_o <= stor_gnt_o & {8{stor_adr_exc_i}};
      stor_prot_exc_o <= stor_gnt_o & {8{stor_prot_exc_i}};
      stor_adr_chk_o <= stor_gnt_o & {8{stor_adr_chk_i}};
      stor_par_chk_o <= stor_gnt_o & {8{stor_par_chk_i}};
    end
  end

  // ****************************************************************
  // Interrupt arbitration
  // ****************************************************************
  logic [7:0] lvl_req;
  logic lvl_any;
  logic [2:0] lvl_idx;
  logic [7:0] prio_lvl_q;
  logic prio_any;
  logic prio_still;
  logic [7:0] lvl_sel;
  logic [2:0] lvl_chan;

  // Level 0 is highest; channel 7 has no level
  assign lvl_req = {mux_table_req_i, int_req_i[iocra_pkg::CH_MUX],
                    int_req_i[iocra_pkg::CH_COMMS], int_req_i[iocra_pkg::CH_SEL4],
                    int_req_i[iocra_pkg::CH_SEL3], int_req_i[iocra_pkg::CH_SEL2],
                    int_req_i[iocra_pkg::CH_SEL1],
                    int_req_i[iocra_pkg::CH_STORE_FAC]};

  iocra_picker #(
    .ORDER(iocra_pkg::LEVEL_ORDER)
  ) u_int_pick (
    .req_i(lvl_req),
    .valid_o(lvl_any),
    .idx_o(lvl_idx)
  );

  assign prio_any = |prio_lvl_q;
  assign prio_still = |(prio_lvl_q & lvl_req);
  assign lvl_sel = 8'h01 << lvl_idx;
  assign lvl_chan = (lvl_idx == 3'h0) ? iocra_pkg::CH_STORE_FAC :
                    (lvl_idx == 3'h5) ? iocra_pkg::CH_COMMS :
                    (lvl_idx >= 3'h6) ? iocra_pkg::CH_MUX : lvl_idx;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prio_lvl_q <= 8'h00;
      int_chan_o <= 3'h0;
    end
    else if (prio_any && !prio_still)
      prio_lvl_q <= 8'h00;
    else if (!prio_any && lvl_any)
    begin
      prio_lvl_q <= lvl_sel;
      int_chan_o <= lvl_chan;
    end
  end

  // Priority outputs mapped back from levels to channel lines
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_prio_o <= 8'h00;
      mux_table_prio_o <= 1'b0;
    end
    else if (prio_any && !prio_still)
    begin
      int_prio_o <= 8'h00;
      mux_table_prio_o <= 1'b0;
    end
    else if (!prio_any && lvl_any)
    begin
      int_prio_o <= {1'b0, lvl_sel[0], lvl_sel[5], lvl_sel[4], lvl_sel[3],
                     lvl_sel[2], lvl_sel[1], lvl_sel[6]};
      mux_table_prio_o <= lvl_sel[7];
    end
  end

  // ****************************************************************
  // Instruction handshake
  // ****************************************************************
  logic instr_take;
  logic [7:0] instr_hit;
  logic instr_acked;
  logic [1:0] instr_cc_sel;
  logic [2:0] instr_chan_q;

  assign instr_take = instr_start_i && !instr_busy_o;
  assign instr_hit = instr_req_o & instr_ack_i;
  assign instr_acked = |instr_hit;
  assign instr_cc_sel = instr_cc_i[instr_chan_q*2 +: 2];

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_req_o <= 8'h00;
      instr_op_o <= '0;
      instr_dev_o <= '0;
      instr_chan_q <= 3'h0;
      instr_busy_o <= 1'b0;
      instr_done_o <= 1'b0;
      instr_cc_o <= '0;
    end
    else
    begin
      instr_done_o <= 1'b0;
      if (instr_take)
      begin
        instr_req_o <= 8'h01 << instr_chan_i;
        instr_op_o <= instr_op_i;
        instr_dev_o <= instr_dev_i;
        instr_chan_q <= instr_chan_i;
        instr_busy_o <= 1'b1;
      end
      else if (instr_acked)
      begin
        instr_req_o <= 8'h00;
        instr_busy_o <= 1'b0;
        instr_done_o <= 1'b1;
        instr_cc_o <= instr_cc_sel;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  a_grant_one_hot: assert property ($onehot0(stor_gnt_o))
    else $error("more than one storage grant");
  a_grant_winner: assert property (st_q == iocra_pkg::IOCRA_ST_IDLE && stor_any
      |=> stor_gnt_o == $past(stor_sel))
    else $error("storage grant not to highest requester");
  a_grant_one_cycle: assert property ($rose(|stor_gnt_o) |=> !(|stor_gnt_o))
    else $error("storage grant longer than one cycle");
  a_grant_gap: assert property ($fell(|stor_gnt_o) |=> !(|stor_gnt_o))
    else $error("grant reissued without rearbitration gap");
  a_error_route: assert property ((((stor_adr_exc_o | stor_prot_exc_o)
      | (stor_adr_chk_o | stor_par_chk_o)) & ~$past(stor_gnt_o)) == 8'h00)
    else $error("storage error sent to channel without grant");
  a_prio_one_hot: assert property ($onehot0({mux_table_prio_o, int_prio_o}))
    else $error("more than one interrupt priority");
  a_prio_top_level: assert property (!prio_any && int_req_i[6]
      |=> int_prio_o[6])
    else $error("storage facility interrupt not first");
  a_instr_addr: assert property (instr_take |=> instr_req_o == 8'h01 << $past(instr_chan_i)
      && instr_dev_o == $past(instr_dev_i))
    else $error("instruction request not to addressed channel");
  a_instr_done: assert property (instr_acked |=> instr_done_o && instr_req_o == 8'h00
      ##1 !instr_done_o)
    else $error("acknowledge not answered by one done pulse");

  c_grant: cover property ($rose(|stor_gnt_o));
  c_prio_table: cover property ($rose(mux_table_prio_o));
  c_instr_done: cover property (instr_done_o);
  c_grant_and_prio: cover property (|stor_gnt_o && |int_prio_o);

endmodule : iocra_top

// ### test/iocra_chan_model.sv
// Behavioural model of the eight channels beyond the arbiter.
// Assumes the bench pulses the want inputs for one cycle to raise a request.
`timescale 1ns/1ns
module iocra_chan_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] stor_want_i,
  input wire logic [7:0] int_want_i,
  input wire logic table_want_i,
  input wire logic [7:0] stor_gnt_i,
  input wire logic [7:0] int_prio_i,
  input wire logic table_prio_i,
  input wire logic [7:0] instr_req_i,
  input wire logic [1:0] ack_wait_i,
  input wire logic [1:0] cc_val_i,
  output logic [7:0] stor_req_o,
  output logic [7:0] int_req_o,
  output logic table_req_o,
  output logic [7:0] instr_ack_o,
  output logic [15:0] instr_cc_o
);
  logic [1:0] wait_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stor_req_o <= 8'h00;
      int_req_o <= 8'h00;
      table_req_o <= 1'b0;
      instr_ack_o <= 8'h00;
      instr_cc_o <= 16'h5555;
      wait_q <= 2'h0;
    end
    else
    begin
      stor_req_o <= (stor_req_o | stor_want_i) & ~stor_gnt_i;
      int_req_o <= (int_req_o | int_want_i) & ~int_prio_i;
      table_req_o <= (table_req_o | table_want_i) & ~table_prio_i;
      instr_ack_o <= 8'h00;
      wait_q <= 2'h0;
      // Code lines toggle outside the answer cycle
      instr_cc_o <= ~instr_cc_o;
      if ((instr_req_i != 8'h00) && (instr_ack_o == 8'h00))
      begin
        wait_q <= wait_q + 2'h1;
        if (wait_q == ack_wait_i)
        begin
          instr_ack_o <= instr_req_i;
          for (int i = 0; i < 8; i++)
            instr_cc_o[2*i +: 2] <= instr_req_i[i] ? cc_val_i : ~cc_val_i;
        end
      end
    end
  end
endmodule : iocra_chan_model

// ### test/iocra_top_bench.sv
// Self-checking bench for the channel arbiter with a channel model.
// Assumes a 50 MHz clock and inputs driven 2 ns after each rising edge.
`timescale 1ns/1ns
module iocra_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] stor_want = 8'h00;
  logic [7:0] int_want = 8'h00;
  logic table_want = 1'b0;
  logic [3:0] err = 4'h0;
  logic start = 1'b0;
  logic [2:0] chan = 3'h0;
  logic [3:0] op = 4'h0;
  logic [7:0] dev = 8'h00;
  logic [1:0] ack_wait = 2'h0;
  logic [1:0] cc_val = 2'h0;
  logic [7:0] s_req, i_req, gnt, e_a, e_p, e_c, e_s, prio, i_rq, ack;
  logic t_req, t_prio, busy, done;
  logic [2:0] i_chan;
  logic [3:0] op_o;
  logic [7:0] dev_o;
  logic [1:0] cc_o;
  logic [15:0] cc_i;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  iocra_top DUT (.core_clk_i(clk), .reset_n_i(rst_n), .stor_req_i(s_req),
    .stor_adr_exc_i(err[0]), .stor_prot_exc_i(err[1]), .stor_adr_chk_i(err[2]),
    .stor_par_chk_i(err[3]), .stor_gnt_o(gnt), .stor_adr_exc_o(e_a),
    .stor_prot_exc_o(e_p), .stor_adr_chk_o(e_c), .stor_par_chk_o(e_s),
    .int_req_i(i_req), .mux_table_req_i(t_req), .int_prio_o(prio),
    .mux_table_prio_o(t_prio), .int_chan_o(i_chan), .instr_start_i(start),
    .instr_chan_i(chan), .instr_op_i(op), .instr_dev_i(dev), .instr_busy_o(busy),
    .instr_done_o(done), .instr_cc_o(cc_o), .instr_req_o(i_rq), .instr_op_o(op_o),
    .instr_dev_o(dev_o), .instr_ack_i(ack), .instr_cc_i(cc_i));

  iocra_chan_model chans (.clk_i(clk), .rst_n_i(rst_n), .stor_want_i(stor_want),
    .int_want_i(int_want), .table_want_i(table_want), .stor_gnt_i(gnt),
    .int_prio_i(prio), .table_prio_i(t_prio), .instr_req_i(i_rq),
    .ack_wait_i(ack_wait), .cc_val_i(cc_val), .stor_req_o(s_req), .int_req_o(i_req),
    .table_req_o(t_req), .instr_ack_o(ack), .instr_cc_o(cc_i));

  initial
  begin
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick

  task automatic wait_for(input int kind);
    int n;
    n = 0;
    while (n < 12 && ((kind == 0 && gnt === 8'h00) || (kind == 1 && {t_prio, prio} === 9'h0)
           || (kind == 2 && done !== 1'b1)))
    begin
      tick();
      n++;
    end
  endtask : wait_for

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic stor_order();
    int exp[8] = '{6, 1, 2, 5, 3, 4, 7, 0};
    stor_want = 8'hff;
    tick();
    stor_want = 8'h00;
    wait_for(0);
    for (int k = 0; k < 8; k++)
    begin
      check("grant", 16'h1 << exp[k], {8'h00, gnt});
      tick();
      check("grant end", 16'h0, {8'h00, gnt});
      tick();
      check("recovery", 16'h0, {8'h00, gnt});
      tick();
    end
  endtask : stor_order

  task automatic stor_errors();
    for (int i = 0; i < 4; i++)
    begin
      stor_want = 8'h08;
      tick();
      stor_want = 8'h00;
      wait_for(0);
      check("err grant", 16'h0008, {8'h00, gnt});
      err = 4'h1 << i;
      tick();
      err = 4'h0;
      check("error lines", 16'h1 << i, {12'h000, e_s[3], e_c[3], e_p[3], e_a[3]});
      check("error others", 16'h0, {8'h00, (e_a | e_p | e_c | e_s) & 8'hf7});
      tick();
    end
  endtask : stor_errors

  task automatic int_order();
    int exp[8] = '{6, 1, 2, 3, 4, 5, 0, 8};
    int_want = 8'hff;
    table_want = 1'b1;
    tick();
    int_want = 8'h00;
    table_want = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      wait_for(1);
      check("priority", 16'h1 << exp[k], {7'h00, t_prio, prio});
      check("int chan", (exp[k] == 8) ? 16'h0 : 16'(exp[k]), {13'h0, i_chan});
      tick();
      tick();
    end
    repeat (3) tick();
    check("spare level", 16'h0, {7'h00, t_prio, prio});
  endtask : int_order

  task automatic instr_run(input logic [2:0] ch);
    start = 1'b1;
    chan = ch;
    op = {1'b1, ch};
    dev = {5'h15, ch};
    ack_wait = ch[1:0];
    cc_val = ch[1:0] ^ 2'h2;
    tick();
    chan = ch + 3'h1;
    op = 4'h0;
    tick();
    start = 1'b0;
    check("instr req", 16'h1 << ch, {8'h00, i_rq});
    check("instr op dev", {4'h0, 1'b1, ch, 5'h15, ch}, {4'h0, op_o, dev_o});
    check("busy", 16'h1, {15'h0, busy});
    wait_for(2);
    check("done", 16'h1, {15'h0, done});
    check("cond code", {14'h0, ch[1:0] ^ 2'h2}, {14'h0, cc_o});
    tick();
    check("idle after", 16'h0, {6'h00, done, busy, i_rq});
  endtask : instr_run

  // ****************************************************************
  // Main sequence and timeout
  // ****************************************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (3) tick();
    stor_order();
    stor_errors();
    int_order();
    for (int c = 0; c < 8; c++)
      instr_run(c[2:0]);
    conclude();
  end
endmodule : iocra_top_bench
